// file: bench/gcr_bank_tb.sv
// Testbench: register bank against a behavioural model
`timescale 1ns/1ps
module gcr_bank_tb;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1;
    logic irq_req_i = 1'b0, pos_pulse_req_i = 1'b0;
    logic axis1_dir_i = 1'b0, axis2_dir_i = 1'b0;
    logic [3:0] probe_sel_i = 4'h0;
    logic [15:0] probe_bus_i = 16'h0;
    logic acc_valid_i, acc_done_o, irq_o, irq_oe_o, axis1_dir_o, axis2_dir_o;
    logic position_pulse_output_o, position_pulse_output_oe_o;
    logic axis2_right_switch_pin_o, axis2_right_switch_pin_oe_o;
    logic [7:0] acc_addr_i;
    logic [31:0] acc_wdata_i, acc_rdata_o, r;
    int n_mismatch = 0, comparisons = 0, cfg = 0;
    bit ok;
    gcr_bank gcr_bank_i (.*);
    gcr_host gcr_host_i (.*);
    initial forever #2 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic go(input logic [6:0] a, input bit wr, input bit tm,
        input logic [31:0] d);
        gcr_host_i.acc(a, wr, tm, d, r, ok);
        if (!ok) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    task automatic pins();
        @(negedge clk_sys_i);
        {irq_req_i, pos_pulse_req_i, axis1_dir_i, axis2_dir_i} = 4'($urandom);
        probe_sel_i = 4'($urandom);
        probe_bus_i = 16'($urandom);
        @(negedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(irq_oe_o, cfg[3]);
        chk(irq_o, cfg[3] & irq_req_i);
        chk(position_pulse_output_o, cfg[3] & pos_pulse_req_i);
        chk(axis1_dir_o, axis1_dir_i ^ cfg[8]);
        chk(axis2_dir_o, axis2_dir_i ^ cfg[9]);
        chk(axis2_right_switch_pin_oe_o, cfg[7]);
        chk(axis2_right_switch_pin_o,
            cfg[7] & probe_bus_i[probe_sel_i]);
    endtask
    initial begin
        void'($urandom(32'h9385));
        repeat (2) @(negedge clk_sys_i);
        reset_i = 1'b0;
        go(7'h00, 0, 0, 32'h0);
        chk(r, 32'h0);
        pins();
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            logic [31:0] d;
            d = $urandom & 32'hfffffbff;
            go(7'h00, 1, i[0], d);
            cfg = d & (i[0] ? 32'h788 : 32'h708);
            go(7'h00, 0, 0, 32'h0);
            chk(r, cfg);
            pins();
        end
        $display("field test done");
        go(7'h05, 1, 0, 32'h7ff);
        go(7'h05, 0, 0, 32'h0);
        chk(r, 32'h0);
        go(7'h00, 0, 0, 32'h0);
        chk(r, cfg);
        $display("unmapped test done");
        go(7'h00, 1, 0, 32'h508);
        go(7'h00, 1, 0, 32'h200);
        cfg = 32'h508;
        go(7'h00, 0, 0, 32'h0);
        chk(r, cfg);
        pins();
        $display("lock test done");
        finish_test();
    end
endmodule
bind gcr_bank gcr_sva gcr_sva_i (.*);

// file: bench/gcr_host.sv
// Partner: host issuing register accesses
`timescale 1ns/1ps
module gcr_host (
    input wire logic clk_sys_i,
    input wire logic acc_done_o,
    input wire logic [31:0] acc_rdata_o,
    output logic acc_valid_i = 1'b0,
    output logic [7:0] acc_addr_i = 8'h55,
    output logic [31:0] acc_wdata_i = 32'h0
);
    task automatic acc(input logic [6:0] a, input bit wr, input bit tm,
        input logic [31:0] d, output logic [31:0] r, output bit ok);
        ok = 1'b0;
        r = 32'h0;
        @(negedge clk_sys_i);
        acc_valid_i = 1'b1;
        acc_addr_i = {wr, a};
        acc_wdata_i = tm ? d : d & ~32'h80;
        @(negedge clk_sys_i);
        acc_valid_i = 1'b0;
        acc_addr_i = ~acc_addr_i;
        acc_wdata_i = ~acc_wdata_i;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (acc_done_o === 1'b1) begin
                ok = 1'b1;
                r = acc_rdata_o;
            end else @(negedge clk_sys_i);
        end
    endtask
endmodule

// file: bench/gcr_sva.sv
// Checker: port properties of the register bank
`timescale 1ns/1ps
module gcr_sva (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic acc_valid_i,
    input wire logic irq_req_i,
    input wire logic [31:0] acc_rdata_o,
    input wire logic acc_done_o,
    input wire logic irq_o,
    input wire logic irq_oe_o,
    input wire logic position_pulse_output_o,
    input wire logic position_pulse_output_oe_o,
    input wire logic axis2_right_switch_pin_o,
    input wire logic axis2_right_switch_pin_oe_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    property p_done; clk_en_i && acc_valid_i |=> acc_done_o; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_idle; clk_en_i && !acc_valid_i |=> !acc_done_o; endproperty
    a_idle: assert property (p_idle) else $error("stray done");
    property p_rsv; (acc_rdata_o & 32'hfffff877) == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    property p_oe; irq_oe_o == position_pulse_output_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("enables differ");
    property p_itri; !irq_oe_o |-> !irq_o; endproperty
    a_itri: assert property (p_itri) else $error("irq driven");
    property p_ptri; !position_pulse_output_oe_o |-> !position_pulse_output_o;
    endproperty
    a_ptri: assert property (p_ptri) else $error("pulse driven");
    property p_stri;
        !axis2_right_switch_pin_oe_o |-> !axis2_right_switch_pin_o;
    endproperty
    a_stri: assert property (p_stri) else $error("pin driven");
    property p_irq;
        irq_oe_o && $past(clk_en_i) |-> irq_o == $past(irq_req_i);
    endproperty
    a_irq: assert property (p_irq) else $error("irq value");
endmodule

// file: hw/gcr_bank.sv
// Top: global configuration register bank behind the decoded access port
`timescale 1ns/1ps
// Summary of operation
// - Reset clears every register to zero unless another value is set.
// - Address bit 7 set (base plus 0x80) marks a write to the base.
// - Compare enable low puts interrupt and position pulse in tristate.
// - Compare enable high drives interrupt and position pulse outputs.
// - Test mode bit routes the probed signal onto the axis 2 switch pin.
// - Bit 8 inverts the direction of motor 1.
// - Bit 9 inverts the direction of motor 2.
// - Once bit 10 is set the configuration register rejects writes.
module gcr_bank (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic acc_valid_i,
    input wire logic [7:0] acc_addr_i,
    input wire logic [gcr_pkg::GCR_DATA_W-1:0] acc_wdata_i,
    input wire logic [gcr_pkg::GCR_PROBE_W-1:0] probe_sel_i,
    input wire logic irq_req_i,
    input wire logic pos_pulse_req_i,
    input wire logic axis1_dir_i,
    input wire logic axis2_dir_i,
    input wire logic [15:0] probe_bus_i,
    output logic [gcr_pkg::GCR_DATA_W-1:0] acc_rdata_o,
    output logic acc_done_o,
    output logic irq_o,
    output logic irq_oe_o,
    output logic position_pulse_output_o,
    output logic position_pulse_output_oe_o,
    output logic axis1_dir_o,
    output logic axis2_dir_o,
    output logic axis2_right_switch_pin_o,
    output logic axis2_right_switch_pin_oe_o
);
    import gcr_pkg::*;
    // ==========================================================
    // Decode
    logic [GCR_CFG_W-1:0] cfg_q;
    logic [GCR_PROBE_W-1:0] probe_q;
    logic [GCR_DATA_W-1:0] rdata_q;
    logic done_q;
    gcr_state_t state_q;
    gcr_state_t state_d;
    wire logic is_write = acc_addr_i[7];
    wire logic [6:0] base_addr = acc_addr_i[6:0];
    wire logic hit_cfg = (base_addr == GCR_ADDR_GLOBAL_CONFIG);
    wire logic locked = cfg_q[GCR_POS_LOCK];
    wire logic cfg_we = acc_valid_i & is_write & hit_cfg & ~locked;
    wire logic [GCR_CFG_W-1:0] cfg_d =
        acc_wdata_i[GCR_CFG_W-1:0] & GCR_CFG_WMASK;
    wire logic [GCR_DATA_W-1:0] rdata_d = hit_cfg ?
        {{(GCR_DATA_W-GCR_CFG_W){1'b0}}, cfg_q} : '0;
    // ==========================================================
    // Access sequencing
    always_comb begin
        state_d = GCR_ST_IDLE;
        if (acc_valid_i) begin
            state_d = is_write ? GCR_ST_WRITE : GCR_ST_READ;
        end
    end
    // ==========================================================
    // Registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cfg_q <= GCR_CFG_RESET;
            rdata_q <= '0;
            done_q <= 1'b0;
            state_q <= GCR_ST_IDLE;
        end else if (clk_en_i) begin
            state_q <= state_d;
            done_q <= acc_valid_i;
            if (cfg_we) begin
                cfg_q <= cfg_d;
            end
            if (acc_valid_i & ~is_write) begin
                rdata_q <= rdata_d;
            end
        end
    end
    // Probe selection is taken from the test-select port
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            probe_q <= GCR_PROBE_RESET;
        end else if (clk_en_i) begin
            probe_q <= probe_sel_i;
        end
    end
    assign acc_rdata_o = rdata_q;
    assign acc_done_o = done_q;
    // ==========================================================
    // Pin stage
    gcr_cfg_if cfg_bus ();
    assign cfg_bus.cmp_en = cfg_q[GCR_POS_CMP_EN];
    assign cfg_bus.test_mode = cfg_q[GCR_POS_TEST_MODE];
    assign cfg_bus.axis1_inv = cfg_q[GCR_POS_AXIS1_INV];
    assign cfg_bus.axis2_inv = cfg_q[GCR_POS_AXIS2_INV];
    assign cfg_bus.probe_sel = probe_q;
    gcr_pin_stage u_pins (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .clk_en_i(clk_en_i),
        .cfg(cfg_bus),
        .irq_req_i(irq_req_i),
        .pos_pulse_req_i(pos_pulse_req_i),
        .axis1_dir_i(axis1_dir_i),
        .axis2_dir_i(axis2_dir_i),
        .probe_bus_i(probe_bus_i),
        .irq_o(irq_o),
        .irq_oe_o(irq_oe_o),
        .position_pulse_output_o(position_pulse_output_o),
        .position_pulse_output_oe_o(position_pulse_output_oe_o),
        .axis1_dir_o(axis1_dir_o),
        .axis2_dir_o(axis2_dir_o),
        .axis2_right_switch_pin_o(axis2_right_switch_pin_o),
        .axis2_right_switch_pin_oe_o(axis2_right_switch_pin_oe_o)
    );
endmodule

// file: hw/gcr_cfg_if.sv
// Interface: configuration fields passed from the register to the pin stage
`timescale 1ns/1ps
interface gcr_cfg_if;
    logic cmp_en;
    logic test_mode;
    logic axis1_inv;
    logic axis2_inv;
    logic [3:0] probe_sel;
    modport src (output cmp_en, output test_mode, output axis1_inv,
        output axis2_inv, output probe_sel);
    modport dst (input cmp_en, input test_mode, input axis1_inv,
        input axis2_inv, input probe_sel);
endinterface

// file: hw/gcr_pin_stage.sv
// Pin stage: output enables, direction inversion and test output routing
`timescale 1ns/1ps
module gcr_pin_stage (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    gcr_cfg_if.dst cfg,
    input wire logic irq_req_i,
    input wire logic pos_pulse_req_i,
    input wire logic axis1_dir_i,
    input wire logic axis2_dir_i,
    input wire logic [15:0] probe_bus_i,
    output logic irq_o,
    output logic irq_oe_o,
    output logic position_pulse_output_o,
    output logic position_pulse_output_oe_o,
    output logic axis1_dir_o,
    output logic axis2_dir_o,
    output logic axis2_right_switch_pin_o,
    output logic axis2_right_switch_pin_oe_o
);
    import gcr_pkg::*;
    // ==========================================================
    // Next values
    wire logic oe_d = cfg.cmp_en;
    wire logic d1_d = axis1_dir_i ^ cfg.axis1_inv;
    wire logic d2_d = axis2_dir_i ^ cfg.axis2_inv;
    wire logic probe_d = probe_bus_i[cfg.probe_sel];
    // ==========================================================
    // Output flops
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
            irq_oe_o <= 1'b0;
            position_pulse_output_o <= 1'b0;
            position_pulse_output_oe_o <= 1'b0;
            axis1_dir_o <= 1'b0;
            axis2_dir_o <= 1'b0;
            axis2_right_switch_pin_o <= 1'b0;
            axis2_right_switch_pin_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= irq_req_i & oe_d;
            irq_oe_o <= oe_d;
            position_pulse_output_o <= pos_pulse_req_i & oe_d;
            position_pulse_output_oe_o <= oe_d;
            axis1_dir_o <= d1_d;
            axis2_dir_o <= d2_d;
            axis2_right_switch_pin_o <= probe_d & cfg.test_mode;
            axis2_right_switch_pin_oe_o <= cfg.test_mode;
        end
    end
endmodule

// file: hw/gcr_pkg.sv
// Package: constants and types of the global configuration register bank
package gcr_pkg;
    // ==========================================================
    // Register map
    localparam logic [6:0] GCR_ADDR_GLOBAL_CONFIG = 7'h00;
    localparam logic [7:0] GCR_WRITE_FLAG = 8'h80;
    localparam int GCR_ADDR_W = 7;
    localparam int GCR_DATA_W = 32;
    localparam int GCR_CFG_W = 11;
    localparam logic [10:0] GCR_CFG_RESET = 11'h000;
    localparam logic [10:0] GCR_CFG_WMASK = 11'h788;
    // ==========================================================
    // Field positions
    localparam int GCR_POS_CMP_EN = 3;
    localparam int GCR_POS_TEST_MODE = 7;
    localparam int GCR_POS_AXIS1_INV = 8;
    localparam int GCR_POS_AXIS2_INV = 9;
    localparam int GCR_POS_LOCK = 10;
    localparam int GCR_PROBE_W = 4;
    localparam logic [3:0] GCR_PROBE_RESET = 4'h0;
    // ==========================================================
    // Access states
    typedef enum logic [2:0] {
        GCR_ST_IDLE = 3'b001,
        GCR_ST_WRITE = 3'b010,
        GCR_ST_READ = 3'b100
    } gcr_state_t;
endpackage
